// >>> rtl/fbsc_regs.sv
// Fieldbus select and drive-command configuration register bank
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module fbsc_regs #(
  parameter int          CYCLES_PER_MS = fbsc_pkg::FBSC_CYCLES_PER_MS,
  parameter logic [31:0] SWITCH_MASK   = fbsc_pkg::FBSC_FB_MASK_RESET
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  input  wire fbsc_pkg::fbsc_bus_req_t   bus_req,
  output var  logic [31:0]               rd_data,
  output var  logic                      wr_refused,
  output var  logic                      rotation_mode,
  output var  logic                      dev_ready,
  output var  logic [31:0]               fieldbus_active,
  output var  logic                      drive_cmd_enabled,
  output var  fbsc_pkg::fbsc_drive_cmd_t drive_cmd,
  output var  logic                      drive_cmd_start
);

  // ---------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------
  logic [31:0]               mode_sel;
  logic [31:0]               boot_delay;
  logic [31:0]               fb_ctrl;
  logic [7:0]                dc_enable;
  fbsc_pkg::fbsc_drive_cmd_t dc_rec;
  logic [31:0]               active_set;
  logic                      ready_now;
  logic [31:0]               next_rd_data;
  logic [31:0]               fb_defined;

  // ---------------------------------------------------------------------
  // Fieldbus bit layout
  // ---------------------------------------------------------------------
  // Interfaces in the low half, protocols in the high half
  function automatic logic fb_bit_defined(input int pos);
    fb_bit_defined = (pos == fbsc_pkg::FBSC_BIT_USB)                  ||
                     (pos == fbsc_pkg::FBSC_BIT_RS485)                ||
                     (pos == fbsc_pkg::FBSC_BIT_RS232)                ||
                     (pos == fbsc_pkg::FBSC_BIT_CAN)                  ||
                     (pos == fbsc_pkg::ethernet_iface_bit)            ||
                     (pos == fbsc_pkg::industrial_ethernet_slave_bit) ||
                     (pos == fbsc_pkg::FBSC_BIT_SPI)                  ||
                     (pos == fbsc_pkg::serial_modbus_protocol_bit)    ||
                     (pos == fbsc_pkg::tcp_modbus_protocol_bit)       ||
                     (pos == fbsc_pkg::industrial_ip_protocol_bit);
  endfunction

  for (genvar i = 0; i < 32; i++) begin : g_fb_bit
    assign fb_defined[i] = fb_bit_defined(i);
  end

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  function automatic logic is_drive_rec(input logic [15:0] a);
    is_drive_rec = (a == fbsc_pkg::FBSC_ADDR_DC_SET1) ||
                   (a == fbsc_pkg::FBSC_ADDR_DC_SET2) ||
                   (a == fbsc_pkg::FBSC_ADDR_DC_SET3) ||
                   (a == fbsc_pkg::FBSC_ADDR_DC_CMD);
  endfunction

  function automatic logic is_writable(input logic [15:0] a);
    is_writable = (a == fbsc_pkg::FBSC_ADDR_MODE_SEL)   ||
                  (a == fbsc_pkg::FBSC_ADDR_BOOT_DELAY) ||
                  (a == fbsc_pkg::FBSC_ADDR_FB_CTRL)    ||
                  (a == fbsc_pkg::FBSC_ADDR_DC_ENABLE)  ||
                  is_drive_rec(a);
  endfunction

  logic        wr_mode;
  logic        wr_delay;
  logic        wr_ctrl;
  logic        wr_dc_en;
  logic        wr_rec_ok;
  logic        wr_bad;
  logic [15:0] addr;
  logic [31:0] wdata;

  assign addr      = bus_req.addr;
  assign wdata     = bus_req.wdata;
  assign wr_mode   = bus_req.wr && (addr == fbsc_pkg::FBSC_ADDR_MODE_SEL);
  assign wr_delay  = bus_req.wr && (addr == fbsc_pkg::FBSC_ADDR_BOOT_DELAY);
  assign wr_ctrl   = bus_req.wr && (addr == fbsc_pkg::FBSC_ADDR_FB_CTRL);
  assign wr_dc_en  = bus_req.wr && (addr == fbsc_pkg::FBSC_ADDR_DC_ENABLE);
  assign wr_rec_ok = bus_req.wr && is_drive_rec(addr) && dc_enable[fbsc_pkg::FBSC_DC_ENABLE_BIT];
  // Record writes while the interface is off are refused, not stored
  assign wr_bad    = bus_req.wr && (!is_writable(addr) || (is_drive_rec(addr) && !wr_rec_ok));

  // ---------------------------------------------------------------------
  // Step input mode select
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mode_sel <= fbsc_pkg::FBSC_MODE_SEL_RESET;
    end else if (wr_mode) begin
      mode_sel <= wdata;
    end
  end

  // Only the documented value one selects rotation-sense input
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rotation_mode <= 1'b0;
    end else begin
      rotation_mode <= (mode_sel == fbsc_pkg::FBSC_MODE_ROTATION);
    end
  end

  // ---------------------------------------------------------------------
  // Power-up readiness
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      boot_delay <= fbsc_pkg::FBSC_BOOT_DELAY_RESET;
    end else if (wr_delay) begin
      boot_delay <= wdata;
    end
  end

  fbsc_ready_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) fbsc_ready_timer_inst (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .delay_ms (boot_delay),
    .ready    (ready_now)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dev_ready <= 1'b0;
    end else begin
      dev_ready <= ready_now;
    end
  end

  // ---------------------------------------------------------------------
  // Fieldbus control and status
  // ---------------------------------------------------------------------
  // Undefined positions are kept at zero in the stored word
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fb_ctrl <= fbsc_pkg::FBSC_FB_CTRL_RESET;
    end else if (wr_ctrl) begin
      fb_ctrl <= wdata & fb_defined;
    end
  end

  fbsc_fieldbus_ctl fbsc_fieldbus_ctl_inst (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .ctrl_wr     (wr_ctrl),
    .ctrl_value  (wdata),
    .switch_mask (SWITCH_MASK),
    .active_set  (active_set)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fieldbus_active <= fbsc_pkg::FBSC_FB_ACTIVE_RESET;
    end else begin
      fieldbus_active <= active_set;
    end
  end

  // ---------------------------------------------------------------------
  // Drive-command interface
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dc_enable <= fbsc_pkg::FBSC_DC_ENABLE_RESET;
    end else if (wr_dc_en) begin
      dc_enable <= wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      drive_cmd_enabled <= 1'b0;
    end else begin
      drive_cmd_enabled <= dc_enable[fbsc_pkg::FBSC_DC_ENABLE_BIT];
    end
  end

  // Record fields take writes only while the interface is enabled
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dc_rec <= '0;
    end else if (wr_rec_ok) begin
      unique case (addr)
        fbsc_pkg::FBSC_ADDR_DC_SET1: begin
          dc_rec.set_value_1 <= wdata;
        end
        fbsc_pkg::FBSC_ADDR_DC_SET2: begin
          dc_rec.set_value_2 <= wdata[15:0];
        end
        fbsc_pkg::FBSC_ADDR_DC_SET3: begin
          dc_rec.set_value_3 <= wdata[7:0];
        end
        fbsc_pkg::FBSC_ADDR_DC_CMD: begin
          dc_rec.command <= wdata[7:0];
        end
        default: begin
          dc_rec <= dc_rec;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      drive_cmd <= '0;
    end else begin
      drive_cmd <= dc_rec;
    end
  end

  // Command write starts the selected mode; pulse aligned with drive_cmd
  logic start_pend;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      start_pend <= 1'b0;
    end else begin
      start_pend <= wr_rec_ok && (addr == fbsc_pkg::FBSC_ADDR_DC_CMD);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      drive_cmd_start <= 1'b0;
    end else begin
      drive_cmd_start <= start_pend;
    end
  end

  // ---------------------------------------------------------------------
  // Refused writes
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wr_refused <= 1'b0;
    end else begin
      wr_refused <= wr_bad;
    end
  end

  // ---------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------
  always_comb begin
    next_rd_data = 32'h00000000;
    unique case (addr)
      fbsc_pkg::FBSC_ADDR_MODE_SEL: begin
        next_rd_data = mode_sel;
      end
      fbsc_pkg::FBSC_ADDR_BOOT_DELAY: begin
        next_rd_data = boot_delay;
      end
      fbsc_pkg::FBSC_ADDR_FB_AVAIL: begin
        next_rd_data = fbsc_pkg::FBSC_FB_AVAIL_VALUE;
      end
      fbsc_pkg::FBSC_ADDR_FB_CTRL: begin
        next_rd_data = fb_ctrl;
      end
      fbsc_pkg::FBSC_ADDR_FB_STAT_CNT: begin
        next_rd_data = {24'h000000, fbsc_pkg::FBSC_FB_STAT_COUNT};
      end
      fbsc_pkg::FBSC_ADDR_FB_MASK: begin
        next_rd_data = SWITCH_MASK & fb_defined;
      end
      fbsc_pkg::FBSC_ADDR_FB_ACTIVE: begin
        next_rd_data = active_set;
      end
      fbsc_pkg::FBSC_ADDR_DC_ENABLE: begin
        next_rd_data = {24'h000000, dc_enable};
      end
      fbsc_pkg::FBSC_ADDR_DC_SET1: begin
        next_rd_data = dc_rec.set_value_1;
      end
      fbsc_pkg::FBSC_ADDR_DC_SET2: begin
        next_rd_data = {16'h0000, dc_rec.set_value_2};
      end
      fbsc_pkg::FBSC_ADDR_DC_SET3: begin
        next_rd_data = {24'h000000, dc_rec.set_value_3};
      end
      fbsc_pkg::FBSC_ADDR_DC_CMD: begin
        next_rd_data = {24'h000000, dc_rec.command};
      end
      default: begin
        next_rd_data = 32'h00000000;
      end
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_data <= 32'h00000000;
    end else if (bus_req.rd) begin
      rd_data <= next_rd_data;
    end else begin
      rd_data <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// >>> pkg/fbsc_pkg.sv
// Package of offsets, field layouts, presets and timing for the fieldbus select bank
package fbsc_pkg;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [15:0] FBSC_ADDR_MODE_SEL    = 16'h205b;
  localparam logic [15:0] FBSC_ADDR_BOOT_DELAY  = 16'h2084;
  localparam logic [15:0] FBSC_ADDR_FB_AVAIL    = 16'h2101;
  localparam logic [15:0] FBSC_ADDR_FB_CTRL     = 16'h2102;
  localparam logic [15:0] FBSC_ADDR_FB_STAT_CNT = 16'h2103;
  localparam logic [15:0] FBSC_ADDR_FB_MASK     = 16'h21f1;
  localparam logic [15:0] FBSC_ADDR_FB_ACTIVE   = 16'h21f2;
  localparam logic [15:0] FBSC_ADDR_DC_ENABLE   = 16'h2290;
  localparam logic [15:0] FBSC_ADDR_DC_SET1     = 16'h22a1;
  localparam logic [15:0] FBSC_ADDR_DC_SET2     = 16'h22a2;
  localparam logic [15:0] FBSC_ADDR_DC_SET3     = 16'h22a3;
  localparam logic [15:0] FBSC_ADDR_DC_CMD      = 16'h22a4;

  // ---------------------------------------------------------------------
  // Fieldbus word layout and presets
  // ---------------------------------------------------------------------
  localparam int FBSC_BIT_USB        = 0;
  localparam int FBSC_BIT_RS485      = 1;
  localparam int FBSC_BIT_RS232      = 2;
  localparam int FBSC_BIT_CAN        = 3;
  localparam int ethernet_iface_bit  = 4;
  localparam int industrial_ethernet_slave_bit = 5;
  localparam int FBSC_BIT_SPI        = 6;
  localparam int serial_modbus_protocol_bit = 16;
  localparam int tcp_modbus_protocol_bit    = 17;
  localparam int industrial_ip_protocol_bit = 18;
  localparam logic [31:0] FBSC_FB_VALID_MASK   = 32'h0007007f;
  localparam logic [31:0] FBSC_FB_AVAIL_VALUE  = 32'h00020010;
  localparam logic [31:0] FBSC_FB_CTRL_RESET   = 32'h00020010;
  localparam logic [31:0] FBSC_FB_MASK_RESET   = 32'h00000000;
  localparam logic [31:0] FBSC_FB_ACTIVE_RESET = 32'h00020010;
  localparam logic [7:0]  FBSC_FB_STAT_COUNT   = 8'h02;
  localparam logic [31:0] FBSC_MODE_SEL_RESET  = 32'h00000000;
  localparam logic [31:0] FBSC_MODE_ROTATION   = 32'h00000001;
  localparam logic [31:0] FBSC_BOOT_DELAY_RESET = 32'h00000000;
  localparam logic [7:0]  FBSC_DC_ENABLE_RESET = 8'h01;
  localparam int          FBSC_DC_ENABLE_BIT   = 0;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int FBSC_CLK_FREQ_KHZ  = 100000;
  localparam int FBSC_DELAY_UNIT_MS = 1;
  localparam int FBSC_CYCLES_PER_MS = FBSC_DELAY_UNIT_MS * FBSC_CLK_FREQ_KHZ;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    FBSC_BOOT_WAIT  = 2'b01,
    FBSC_BOOT_READY = 2'b10
  } fbsc_boot_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fbsc_bus_req_t;

  typedef struct packed {
    logic [31:0] set_value_1;
    logic [15:0] set_value_2;
    logic [7:0]  set_value_3;
    logic [7:0]  command;
  } fbsc_drive_cmd_t;

endpackage

// >>> rtl/fbsc_ready_timer.sv
// Power-up readiness delay counted in milliseconds
`timescale 1ns/10ps
`default_nettype none
module fbsc_ready_timer #(
  parameter int CYCLES_PER_MS = fbsc_pkg::FBSC_CYCLES_PER_MS
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [31:0] delay_ms,
  output var  logic        ready
);

  fbsc_pkg::fbsc_boot_state_t state;
  logic [31:0] tick_cnt;
  logic [31:0] ms_cnt;
  logic        ms_tick;

  assign ms_tick = (tick_cnt == 32'(CYCLES_PER_MS - 1));

  always_ff @(posedge clk_sys) begin
    if (!rst_b || state == fbsc_pkg::FBSC_BOOT_READY || ms_tick) begin
      tick_cnt <= 32'h00000000;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ms_cnt <= 32'h00000000;
    end else if (ms_tick && ms_cnt != 32'hffffffff) begin
      ms_cnt <= ms_cnt + 32'h00000001;
    end
  end

  // Ready is sticky once the delay has elapsed
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= fbsc_pkg::FBSC_BOOT_WAIT;
    end else begin
      unique case (state)
        fbsc_pkg::FBSC_BOOT_WAIT: begin
          if (ms_cnt >= delay_ms) state <= fbsc_pkg::FBSC_BOOT_READY;
        end
        fbsc_pkg::FBSC_BOOT_READY: state <= fbsc_pkg::FBSC_BOOT_READY;
      endcase
    end
  end

  assign ready = (state == fbsc_pkg::FBSC_BOOT_READY);

endmodule
`default_nettype wire

// >>> rtl/fbsc_fieldbus_ctl.sv
// Applies control writes to the active fieldbus set through the switchable mask
`timescale 1ns/10ps
`default_nettype none
module fbsc_fieldbus_ctl (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        ctrl_wr,
  input  wire logic [31:0] ctrl_value,
  input  wire logic [31:0] switch_mask,
  output var  logic [31:0] active_set
);

  logic [31:0] next_active;

  // Only switchable bits follow the control word
  for (genvar i = 0; i < 32; i++) begin : g_bit
    assign next_active[i] = (switch_mask[i] && fbsc_pkg::FBSC_FB_VALID_MASK[i]) ?
                            ctrl_value[i] : active_set[i];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      active_set <= fbsc_pkg::FBSC_FB_ACTIVE_RESET;
    end else if (ctrl_wr) begin
      active_set <= next_active;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/fbsc_regs_sva.sv
// Port assertions for the fieldbus select bank
`timescale 1ns/10ps
`default_nettype none
module fbsc_regs_sva #(
  parameter int          CYCLES_PER_MS = 4,
  parameter logic [31:0] SWITCH_MASK   = 32'h0
) (
  input wire logic                      clk_sys,
  input wire logic                      rst_b,
  input wire fbsc_pkg::fbsc_bus_req_t   bus_req,
  input wire logic [31:0]               rd_data,
  input wire logic                      wr_refused,
  input wire logic                      rotation_mode,
  input wire logic                      dev_ready,
  input wire logic [31:0]               fieldbus_active,
  input wire logic                      drive_cmd_enabled,
  input wire fbsc_pkg::fbsc_drive_cmd_t drive_cmd,
  input wire logic                      drive_cmd_start
);
  // ------------------------------
  // Decoded requests
  // ------------------------------
  localparam logic [31:0] SW = SWITCH_MASK & 32'h0007007f;
  wire logic w_mode = bus_req.wr && bus_req.addr == 16'h205b;
  wire logic w_ctrl = bus_req.wr && bus_req.addr == 16'h2102;
  wire logic w_cmd  = bus_req.wr && bus_req.addr == 16'h22a4;
  wire logic w_ena  = bus_req.wr && bus_req.addr == 16'h2290;
  wire logic w_ro   = bus_req.wr && bus_req.addr inside {16'h2101, 16'h2103, 16'h21f1, 16'h21f2};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_avail_fixed: assert property (
    bus_req.rd && bus_req.addr == 16'h2101 |=> rd_data == 32'h00020010)
    else $error("availability read wrong");
  chk_count_two: assert property (
    bus_req.rd && bus_req.addr == 16'h2103 |=> rd_data == 32'h00000002)
    else $error("status count read wrong");
  chk_mode_select: assert property (
    w_mode |-> ##2 rotation_mode == ($past(bus_req.wdata, 2) == 32'h1))
    else $error("mode output wrong");
  chk_ro_refused: assert property (
    w_ro |=> wr_refused)
    else $error("read-only write not refused");
  chk_active_cause: assert property (
    !$stable(fieldbus_active) |-> $past(w_ctrl, 2))
    else $error("active set changed without control write");
  chk_fixed_bits: assert property (
    (fieldbus_active & ~SW) == (32'h00020010 & ~SW))
    else $error("non-switchable bus changed");
  chk_active_apply: assert property (
    w_ctrl |-> ##2 (fieldbus_active & SW) == ($past(bus_req.wdata, 2) & SW))
    else $error("control write not applied");
  chk_start_cause: assert property (
    w_cmd |-> ##2 drive_cmd_start == !$past(wr_refused))
    else $error("start pulse wrong");
  chk_start_value: assert property (
    drive_cmd_start |-> ($past(bus_req.wdata, 2) & 32'hff) == {24'h0, drive_cmd.command})
    else $error("command value wrong at start");
  chk_enable_follow: assert property (
    w_ena |-> ##2 ($past(bus_req.wdata, 2) & 32'h1) == {31'h0, drive_cmd_enabled})
    else $error("drive interface enable wrong");
  chk_ready_sticky: assert property (
    dev_ready |=> dev_ready)
    else $error("ready dropped");
endmodule
`default_nettype wire

// >>> testbench/fbsc_regs_bench.sv
// Self-checking bench for the fieldbus select bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) check_val((g), (e))
module fbsc_regs_bench;
  localparam logic [31:0] SMASK = 32'h0003007f;
  localparam logic [31:0] M     = SMASK & 32'h0007007f;
  logic                      clk_sys    = 1'b0;
  logic                      rst_b      = 1'b0;
  fbsc_pkg::fbsc_bus_req_t   bus_req    = '0;
  logic [31:0]               rd_data;
  logic                      wr_refused;
  logic                      rotation_mode;
  logic                      dev_ready;
  logic [31:0]               fieldbus_active;
  logic                      drive_cmd_enabled;
  fbsc_pkg::fbsc_drive_cmd_t drive_cmd;
  logic                      drive_cmd_start;
  int                        fail_count = 0;
  int                        checked    = 0;
  logic [31:0]               act        = 32'h00020010;
  logic [31:0]               rv;
  logic                      rf;

  always #5 clk_sys = ~clk_sys;

  fbsc_regs #(.CYCLES_PER_MS(4), .SWITCH_MASK(SMASK)) fbsc_regs_inst (
    .clk_sys          (clk_sys),
    .rst_b            (rst_b),
    .bus_req          (bus_req),
    .rd_data          (rd_data),
    .wr_refused       (wr_refused),
    .rotation_mode    (rotation_mode),
    .dev_ready        (dev_ready),
    .fieldbus_active  (fieldbus_active),
    .drive_cmd_enabled(drive_cmd_enabled),
    .drive_cmd        (drive_cmd),
    .drive_cmd_start  (drive_cmd_start)
  );

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic check_val(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic test_done;
    $display("Counts: %0d compared, %0d mismatched", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One strobe cycle, then answer and refusal sampled in the next cycle
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req.wr    <= w;
    bus_req.rd    <= !w;
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
    #1;
    rv = rd_data;
    rf = wr_refused;
  endtask

  task automatic look(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_ready;
    #1;
    `CHK(dev_ready, 1'b0);
    look(3);
    `CHK(dev_ready, 1'b1);
    $display("ready test done");
  endtask

  task automatic t_reset;
    logic [15:0] a [12] = '{16'h205b, 16'h2084, 16'h2101, 16'h2102, 16'h2103, 16'h21f1,
                            16'h21f2, 16'h2290, 16'h22a1, 16'h22a2, 16'h22a3, 16'h22a4};
    logic [31:0] e [12] = '{32'h0, 32'h0, 32'h00020010, 32'h00020010, 32'h2, SMASK,
                            32'h00020010, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
    `CHK(fieldbus_active, 32'h00020010);
    `CHK(drive_cmd_enabled, 1'b1);
    foreach (a[i]) begin
      bus(1'b0, a[i], 32'h0);
      `CHK(rv, e[i]);
    end
    $display("preset test done");
  endtask

  task automatic t_mode;
    logic [31:0] v [3] = '{32'h1, 32'h2, 32'h0};
    foreach (v[i]) begin
      bus(1'b1, 16'h205b, v[i]);
      look(1);
      `CHK(rotation_mode, v[i] == 32'h1);
      bus(1'b0, 16'h205b, 32'h0);
      `CHK(rv, v[i]);
    end
    bus(1'b1, 16'h2084, 32'h5);
    bus(1'b0, 16'h2084, 32'h0);
    `CHK(rv, 32'h5);
    `CHK(dev_ready, 1'b1);
    $display("mode test done");
  endtask

  task automatic t_fieldbus;
    int          b [10] = '{0, 1, 2, 3, 4, 5, 6, 16, 17, 18};
    logic [31:0] w;
    foreach (b[i]) begin
      w = 32'h1 << b[i];
      act = (act & ~M) | (w & M);
      bus(1'b1, 16'h2102, w);
      look(1);
      `CHK(fieldbus_active, act);
      bus(1'b0, 16'h2102, 32'h0);
      `CHK(rv, w);
      bus(1'b0, 16'h21f2, 32'h0);
      `CHK(rv, act);
    end
    bus(1'b1, 16'h2102, 32'hffffffff);
    bus(1'b0, 16'h2102, 32'h0);
    `CHK(rv, 32'h0007007f);
    bus(1'b0, 16'h21f2, 32'h0);
    `CHK(rv, M);
    $display("fieldbus test done");
  endtask

  task automatic t_readonly;
    logic [15:0] a [5] = '{16'h2101, 16'h2103, 16'h21f1, 16'h21f2, 16'h3000};
    logic [31:0] e [5] = '{32'h00020010, 32'h2, SMASK, M, 32'h0};
    foreach (a[i]) begin
      bus(1'b1, a[i], 32'h5a5a5a5a);
      `CHK(rf, 1'b1);
      bus(1'b0, a[i], 32'h0);
      `CHK(rv, e[i]);
    end
    `CHK(fieldbus_active, M);
    $display("read-only test done");
  endtask

  task automatic t_drive;
    bus(1'b1, 16'h22a1, 32'h12345678);
    bus(1'b1, 16'h22a2, 32'h1234abcd);
    bus(1'b1, 16'h22a3, 32'h0000005a);
    bus(1'b1, 16'h22a4, 32'h00000005);
    `CHK(rf, 1'b0);
    look(1);
    `CHK(drive_cmd_start, 1'b1);
    `CHK(drive_cmd, 64'h12345678_abcd_5a_05);
    look(1);
    `CHK(drive_cmd_start, 1'b0);
    bus(1'b1, 16'h2290, 32'h0);
    look(1);
    `CHK(drive_cmd_enabled, 1'b0);
    bus(1'b1, 16'h22a4, 32'h7);
    `CHK(rf, 1'b1);
    look(1);
    `CHK(drive_cmd_start, 1'b0);
    bus(1'b0, 16'h22a4, 32'h0);
    `CHK(rv, 32'h5);
    bus(1'b1, 16'h2290, 32'h1);
    bus(1'b0, 16'h2290, 32'h0);
    `CHK(rv, 32'h1);
    `CHK(drive_cmd_enabled, 1'b1);
    bus(1'b1, 16'h22a4, 32'h9);
    look(1);
    `CHK(drive_cmd_start, 1'b1);
    `CHK(drive_cmd.command, 8'h09);
    $display("drive command test done");
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_ready;
    t_reset;
    t_mode;
    t_fieldbus;
    t_readonly;
    t_drive;
    test_done;
  end

  // Tests need well under 1000 cycles
  initial begin
    #50000;
    fail_count++;
    test_done;
  end
endmodule

bind fbsc_regs fbsc_regs_sva #(
  .CYCLES_PER_MS(CYCLES_PER_MS),
  .SWITCH_MASK  (SWITCH_MASK)
) fbsc_regs_sva_inst (
  .clk_sys          (clk_sys),
  .rst_b            (rst_b),
  .bus_req          (bus_req),
  .rd_data          (rd_data),
  .wr_refused       (wr_refused),
  .rotation_mode    (rotation_mode),
  .dev_ready        (dev_ready),
  .fieldbus_active  (fieldbus_active),
  .drive_cmd_enabled(drive_cmd_enabled),
  .drive_cmd        (drive_cmd),
  .drive_cmd_start  (drive_cmd_start)
);
`default_nettype wire
